/* File: rtm_ctrl.sv */
// resistive touch measurement controller: patterns, pen detect, irq
//
// Contract
// R1: 4-wire X: Vref+ on X+, Vref- on X-, Y+ to converter.
// R2: 4-wire Y: Vref+ on Y+, Vref- on Y-, X+ to converter.
// R3: pressure: Vref+ on X+, Vref- on Y-; sample Y+ then X-.
// R4: position result is 12-bit ratio code, full scale 4095.
// R5: 4-wire pen detect pulls X+ via resistor; X+ fall means touch.
// R6: touch raises interrupt or launches acquisition by mode.
// R7: pen detection runs before any conversion starts; manual-mode requests here convert with no pen detect first.
// R8: detected touch sets the touch-detect flag.
// R9: status read clears flag and releases interrupt together.
// R10: touch-detect-only mode drives interrupt output low on touch.
// R11: host should select the 200 kOhm pull-up.
// R12: host may lengthen settle delay for high-resistance panels.
// R13: host sets 3-bit multitouch selects by panel resistance.
// R14: 5-wire X ties left corners and right corners as bars.
// R15: 5-wire Y ties top corners and bottom corners as bars.
// R16: 5-wire conversions route wiper to converter input; here 5-wire Z1/Z2 requests convert with all switches open.
// R17: 5-wire pen detect pulls bottom-right up, grounds wiper.
// R18: 5-wire pen detect watches bottom-right drop, sets flag.
// R19: interrupt output active low open drain; touch or data.
// R20: touch-detect-only mode persists until manual mode programmed; here set_pen_trigger_mode also ends it.
// R21: open all switches before closing next pattern.
`timescale 1ns/10ps
`include "rtm_defs.svh"
module rtm_ctrl
  import rtm_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic                    five_wire,
  input  wire logic                    set_touch_detect_only_mode,
  input  wire logic                    set_manual_mode,
  input  wire logic                    set_pen_trigger_mode,
  input  wire logic [1:0]              touch_detect_pullup_select,
  input  wire logic [`RTM_SETTLE_W-1:0] settle_delay,
  input  wire logic [2:0]              x_multitouch_resistor_select,
  input  wire logic [2:0]              y_multitouch_resistor_select,
  input  wire logic                    meas_req,
  input  wire rtm_chan_e               meas_chan,
  input  wire logic                    pen_sense_low,
  input  wire logic                    adc_done,
  input  wire logic [`RTM_ADC_W-1:0]   adc_code,
  input  wire logic                    status_read,
  output logic [`RTM_SW_W-1:0]         switch_ctrl,
  output logic [1:0]                   pullup_sel,
  output logic [2:0]                   x_rsel,
  output logic [2:0]                   y_rsel,
  output logic                         adc_start,
  output logic [`RTM_ADC_W-1:0]        result,
  output logic                         result_valid,
  output logic                         touch_detect_flag,
  output logic                         data_ready_flag,
  output logic                         touch_detect_only_mode,
  output logic                         pen_trigger_mode,
  output logic                         interrupt_request_n_out,
  output logic                         interrupt_request_n_oe
);
  rtm_state_e                state_r, state_nxt;
  rtm_chan_e                 chan_r;
  rtm_chan_e                 target_r;
  logic [`RTM_SETTLE_W-1:0]  cnt_r;
  logic [`RTM_SW_W-1:0]      sw_r;
  logic [`RTM_SW_W-1:0]      pattern;
  logic                      pen_prev_r;
  logic                      flag_r;
  logic                      drdy_r;
  logic                      touch_detect_only_mode_r;
  logic                      pentrig_r;
  logic                      want_r;
  logic [`RTM_ADC_W-1:0]     result_r;
  logic                      rvalid_r;
  logic                      adc_start_r;
  logic [1:0]                seq_r;

  wire in_pen     = (chan_r == RTM_CH_PEN) && (state_r == RTM_ST_HOLD);
  // rising of the low indicator equals the sensed node falling
  wire touch_evt  = in_pen && pen_sense_low && !pen_prev_r; // see R5 R18
  wire any_mode   = touch_detect_only_mode_r | pentrig_r;
  wire cnt_zero   = (cnt_r == '0);
  wire launch     = touch_evt && pentrig_r; // see R6
  wire next_req   = meas_req && !any_mode;
  wire seq_more   = pentrig_r && (seq_r != 2'h0) && adc_done;
  wire drop_pen   = state_r == RTM_ST_HOLD && chan_r == RTM_CH_PEN;
  // a finished manual run parks in idle so the next request is taken
  wire to_idle    = (target_r == RTM_CH_IDLE);

  rtm_switch_map u_map (
    .chan      (chan_r),
    .five_wire (five_wire),
    .pattern   (pattern)
  );

  function automatic rtm_chan_e seq_chan(input logic [1:0] idx);
    case (idx)
      2'h1:    seq_chan = RTM_CH_Y;
      default: seq_chan = RTM_CH_X;
    endcase
  endfunction : seq_chan

  // pick the next state; pen detect first in either auto mode
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RTM_ST_IDLE: begin
        if (any_mode || next_req) begin
          state_nxt = RTM_ST_BREAK;
        end
      end
      RTM_ST_BREAK: begin
        if (cnt_zero) begin
          state_nxt = to_idle ? RTM_ST_IDLE : RTM_ST_SETTLE;
        end
      end
      RTM_ST_SETTLE: begin
        if (cnt_zero) begin
          state_nxt = RTM_ST_HOLD;
        end
      end
      RTM_ST_HOLD: begin
        if (launch || seq_more || (!any_mode && !drop_pen && adc_done)) begin
          state_nxt = RTM_ST_BREAK;
        end else if (!any_mode && drop_pen) begin
          state_nxt = RTM_ST_BREAK;
        end else if (seq_r == 2'h0 && pentrig_r && adc_done) begin
          state_nxt = RTM_ST_BREAK;
        end
      end
      default: state_nxt = RTM_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r  <= RTM_ST_IDLE;
      chan_r   <= RTM_CH_IDLE;
      target_r <= RTM_CH_IDLE;
      cnt_r    <= '0;
      sw_r     <= '0;
      seq_r    <= 2'h0;
    end else begin
      state_r <= state_nxt;
      case (state_r)
        RTM_ST_IDLE: begin
          sw_r <= '0;
          if (any_mode) begin
            target_r <= RTM_CH_PEN; // see R7
          end else if (next_req) begin
            target_r <= meas_chan;
          end
          cnt_r <= {12'h000, `RTM_BREAK_CYC};
        end
        RTM_ST_BREAK: begin
          sw_r  <= '0; // see R21
          chan_r <= target_r;
          if (cnt_zero) begin
            cnt_r <= settle_delay;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        RTM_ST_SETTLE: begin
          sw_r <= pattern;
          if (!cnt_zero) begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        RTM_ST_HOLD: begin
          sw_r <= pattern;
          cnt_r <= {12'h000, `RTM_BREAK_CYC};
          if (launch) begin
            target_r <= RTM_CH_X;
            seq_r    <= 2'h1;
          end else if (seq_more) begin
            target_r <= seq_chan(seq_r);
            seq_r    <= (seq_r == 2'h1) ? 2'h0 : seq_r + 2'h1;
          end else if (pentrig_r && adc_done) begin
            target_r <= RTM_CH_PEN;
          end else if (!any_mode && (drop_pen || adc_done)) begin
            target_r <= RTM_CH_IDLE;
          end
        end
        default: sw_r <= '0;
      endcase
    end
  end

  // conversion kicked once the pattern has settled; never for pen
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      adc_start_r <= 1'b0;
      result_r    <= '0;
      rvalid_r    <= 1'b0;
      pen_prev_r  <= 1'b0;
    end else begin
      adc_start_r <= (state_r == RTM_ST_SETTLE) && cnt_zero &&
                     (chan_r != RTM_CH_PEN) && (chan_r != RTM_CH_IDLE);
      rvalid_r    <= adc_done && state_r == RTM_ST_HOLD && !drop_pen;
      if (adc_done && state_r == RTM_ST_HOLD && !drop_pen) begin
        result_r <= adc_code; // see R4
      end
      pen_prev_r  <= in_pen && pen_sense_low;
    end
  end

  // mode bits and sticky flags; a new event beats the read clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      touch_detect_only_mode_r  <= 1'b0;
      pentrig_r <= 1'b0;
      flag_r    <= 1'b0;
      drdy_r    <= 1'b0;
      want_r    <= 1'b0;
    end else begin
      if (set_manual_mode) begin // see R20
        touch_detect_only_mode_r  <= 1'b0;
        pentrig_r <= 1'b0;
      end else if (set_touch_detect_only_mode) begin
        touch_detect_only_mode_r  <= 1'b1;
        pentrig_r <= 1'b0;
      end else if (set_pen_trigger_mode) begin
        touch_detect_only_mode_r  <= 1'b0;
        pentrig_r <= 1'b1;
      end
      if (touch_evt) begin
        flag_r <= 1'b1; // see R8 R18
      end else if (status_read) begin
        flag_r <= 1'b0; // see R9
      end
      if (pentrig_r && seq_r == 2'h0 && adc_done && !drop_pen &&
          state_r == RTM_ST_HOLD) begin
        drdy_r <= 1'b1;
      end else if (status_read) begin
        drdy_r <= 1'b0;
      end
      // touch_detect_only_mode touches and finished pen-trigger bursts request irq
      if ((touch_evt && touch_detect_only_mode_r) || (pentrig_r && seq_r == 2'h0 &&
          adc_done && !drop_pen && state_r == RTM_ST_HOLD)) begin
        want_r <= 1'b1; // see R10 R19
      end else if (status_read) begin
        want_r <= 1'b0; // see R9
      end
    end
  end

  assign switch_ctrl             = sw_r;
  assign pullup_sel              = touch_detect_pullup_select;
  assign x_rsel                  = x_multitouch_resistor_select;
  assign y_rsel                  = y_multitouch_resistor_select;
  assign adc_start               = adc_start_r;
  assign result                  = result_r;
  assign result_valid            = rvalid_r;
  assign touch_detect_flag       = flag_r;
  assign data_ready_flag         = drdy_r;
  assign touch_detect_only_mode  = touch_detect_only_mode_r;
  assign pen_trigger_mode        = pentrig_r;
  // open drain: pull low only, enable low while driving
  assign interrupt_request_n_out = 1'b0; // see R19
  assign interrupt_request_n_oe  = ~want_r;
endmodule : rtm_ctrl

/* File: rtm_defs.svh */
// constants for the resistive touch measurement controller
`ifndef RTM_DEFS_SVH
`define RTM_DEFS_SVH
`define RTM_ADC_W        12
`define RTM_FULL_SCALE   12'hFFF
`define RTM_SW_W         16
`define RTM_BREAK_CYC    4'h4
`define RTM_PULL_200K    2'h1
`define RTM_SETTLE_W     16
// switch bit positions of the electrode pattern word
`define RTM_SW_REFP_XP   0
`define RTM_SW_REFN_XM   1
`define RTM_SW_REFP_YP   2
`define RTM_SW_REFN_YM   3
`define RTM_SW_REFN_YM_Z 4
`define RTM_SW_ADC_YP    5
`define RTM_SW_ADC_XP    6
`define RTM_SW_ADC_XM    7
`define RTM_SW_PULL_XP   8
`define RTM_SW_TIE_LEFT  9
`define RTM_SW_TIE_RIGHT 10
`define RTM_SW_TIE_TOP   11
`define RTM_SW_TIE_BOT   12
`define RTM_SW_ADC_WIPER 13
`define RTM_SW_GND_WIPER 14
`define RTM_SW_PULL_BR   15
`endif

/* File: rtm_pkg.sv */
// types for the resistive touch measurement controller
package rtm_pkg;
  typedef enum logic [2:0] {
    RTM_CH_X  = 3'h0,
    RTM_CH_Y  = 3'h1,
    RTM_CH_Z1 = 3'h2,
    RTM_CH_Z2 = 3'h3,
    RTM_CH_PEN = 3'h4,
    RTM_CH_IDLE = 3'h5
  } rtm_chan_e;
  typedef enum logic [3:0] {
    RTM_ST_IDLE   = 4'b0001,
    RTM_ST_BREAK  = 4'b0010,
    RTM_ST_SETTLE = 4'b0100,
    RTM_ST_HOLD   = 4'b1000
  } rtm_state_e;
endpackage : rtm_pkg

/* File: rtm_switch_map.sv */
// electrode switch pattern decoder for 4-wire and 5-wire panels
`timescale 1ns/10ps
`include "rtm_defs.svh"
module rtm_switch_map
  import rtm_pkg::*;
(
  input  wire rtm_chan_e       chan,
  input  wire logic            five_wire,
  output logic [`RTM_SW_W-1:0] pattern
);
  always_comb begin
    pattern = '0;
    if (!five_wire) begin
      case (chan)
        RTM_CH_X: begin // see R1
          pattern[`RTM_SW_REFP_XP] = 1'b1;
          pattern[`RTM_SW_REFN_XM] = 1'b1;
          pattern[`RTM_SW_ADC_YP]  = 1'b1;
        end
        RTM_CH_Y: begin // see R2
          pattern[`RTM_SW_REFP_YP] = 1'b1;
          pattern[`RTM_SW_REFN_YM] = 1'b1;
          pattern[`RTM_SW_ADC_XP]  = 1'b1;
        end
        RTM_CH_Z1: begin // see R3
          pattern[`RTM_SW_REFP_XP]   = 1'b1;
          pattern[`RTM_SW_REFN_YM_Z] = 1'b1;
          pattern[`RTM_SW_ADC_YP]    = 1'b1;
        end
        RTM_CH_Z2: begin // see R3
          pattern[`RTM_SW_REFP_XP]   = 1'b1;
          pattern[`RTM_SW_REFN_YM_Z] = 1'b1;
          pattern[`RTM_SW_ADC_XM]    = 1'b1;
        end
        RTM_CH_PEN: begin // see R5
          pattern[`RTM_SW_PULL_XP]   = 1'b1;
          pattern[`RTM_SW_REFN_YM_Z] = 1'b1;
        end
        default: pattern = '0;
      endcase
    end else begin
      case (chan)
        RTM_CH_X: begin // see R14
          pattern[`RTM_SW_TIE_LEFT]  = 1'b1;
          pattern[`RTM_SW_TIE_RIGHT] = 1'b1;
          pattern[`RTM_SW_REFP_XP]   = 1'b1;
          pattern[`RTM_SW_REFN_XM]   = 1'b1;
          pattern[`RTM_SW_ADC_WIPER] = 1'b1; // see R16
        end
        RTM_CH_Y: begin // see R15
          pattern[`RTM_SW_TIE_TOP]   = 1'b1;
          pattern[`RTM_SW_TIE_BOT]   = 1'b1;
          pattern[`RTM_SW_REFP_YP]   = 1'b1;
          pattern[`RTM_SW_REFN_YM]   = 1'b1;
          pattern[`RTM_SW_ADC_WIPER] = 1'b1; // see R16
        end
        RTM_CH_PEN: begin // see R17
          pattern[`RTM_SW_PULL_BR]   = 1'b1;
          pattern[`RTM_SW_GND_WIPER] = 1'b1;
        end
        default: pattern = '0;
      endcase
    end
  end
endmodule : rtm_switch_map

/* File: rtm_ctrl_monitor.sv */
// assertion checker for the touch measurement controller ports
`timescale 1ns/10ps
`include "rtm_defs.svh"
module rtm_ctrl_monitor (
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire logic                  five_wire,
  input wire logic                  set_manual_mode,
  input wire logic                  set_pen_trigger_mode,
  input wire logic                  pen_sense_low,
  input wire logic                  adc_done,
  input wire logic [`RTM_ADC_W-1:0] adc_code,
  input wire logic                  status_read,
  input wire logic [`RTM_SW_W-1:0]  switch_ctrl,
  input wire logic                  adc_start,
  input wire logic [`RTM_ADC_W-1:0] result,
  input wire logic                  result_valid,
  input wire logic                  touch_detect_flag,
  input wire logic                  touch_detect_only_mode,
  input wire logic                  pen_trigger_mode,
  input wire logic                  interrupt_request_n_out,
  input wire logic                  interrupt_request_n_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire pen_bias = switch_ctrl[`RTM_SW_PULL_XP] | switch_ctrl[`RTM_SW_PULL_BR];
  sequence s_open4; (switch_ctrl == '0) [*4]; endsequence
  sequence s_touch; $rose(pen_sense_low) && pen_bias && touch_detect_only_mode;
  endsequence
  property p_gap; $fell(|switch_ctrl) |-> s_open4; endproperty
  a_gap: assert property (p_gap) else $error("switch gap too short");
  property p_nomix;
    switch_ctrl != '0 && $past(switch_ctrl) != '0 |-> $stable(switch_ctrl);
  endproperty
  a_nomix: assert property (p_nomix) else $error("pattern changed");
  property p_flag; s_touch |-> ##[1:2] touch_detect_flag; endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_irq; s_touch |-> ##[1:2] !interrupt_request_n_oe; endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  property p_read; status_read && !pen_sense_low |=> !touch_detect_flag;
  endproperty
  a_read: assert property (p_read) else $error("flag not cleared");
  property p_rel;
    status_read && !pen_sense_low && touch_detect_only_mode
      |=> interrupt_request_n_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("irq not released");
  property p_od; !interrupt_request_n_oe |-> !interrupt_request_n_out;
  endproperty
  a_od: assert property (p_od) else $error("irq line not low");
  property p_res; adc_done |=> result_valid && result == $past(adc_code);
  endproperty
  a_res: assert property (p_res) else $error("result wrong");
  property p_wiper;
    adc_start && five_wire |-> switch_ctrl[`RTM_SW_ADC_WIPER];
  endproperty
  a_wiper: assert property (p_wiper) else $error("wiper unrouted");
  property p_conv; adc_start |-> switch_ctrl != '0 && !pen_bias; endproperty
  a_conv: assert property (p_conv) else $error("bad conversion");
  property p_keep;
    touch_detect_only_mode && !set_manual_mode && !set_pen_trigger_mode
      |=> touch_detect_only_mode;
  endproperty
  a_keep: assert property (p_keep) else $error("mode dropped");
  property p_man;
    set_manual_mode |=> !touch_detect_only_mode && !pen_trigger_mode;
  endproperty
  a_man: assert property (p_man) else $error("manual not taken");
endmodule : rtm_ctrl_monitor
bind rtm_ctrl rtm_ctrl_monitor u_mon (.mclk(mclk), .reset(reset),
  .five_wire(five_wire), .set_manual_mode(set_manual_mode),
  .set_pen_trigger_mode(set_pen_trigger_mode), .pen_sense_low(pen_sense_low),
  .adc_done(adc_done), .adc_code(adc_code), .status_read(status_read),
  .switch_ctrl(switch_ctrl), .adc_start(adc_start), .result(result),
  .result_valid(result_valid), .touch_detect_flag(touch_detect_flag),
  .touch_detect_only_mode(touch_detect_only_mode),
  .pen_trigger_mode(pen_trigger_mode),
  .interrupt_request_n_out(interrupt_request_n_out),
  .interrupt_request_n_oe(interrupt_request_n_oe));

/* File: rtm_panel_model.sv */
// resistive panel: sensed node drops only when biased and pressed
`timescale 1ns/10ps
`include "rtm_defs.svh"
module rtm_panel_model (
  input  wire logic                 mclk,
  input  wire logic [`RTM_SW_W-1:0] switch_ctrl,
  input  wire logic                 five_wire,
  input  wire logic                 touch,
  output logic                      pen_sense_low
);
  // unbiased node floats at the pull-up level, so no drop is seen
  always_ff @(posedge mclk) begin
    pen_sense_low <= touch & (five_wire ?
      switch_ctrl[`RTM_SW_PULL_BR] & switch_ctrl[`RTM_SW_GND_WIPER] :
      switch_ctrl[`RTM_SW_PULL_XP]);
  end
endmodule : rtm_panel_model

/* File: rtm_ctrl_bench.sv */
// self-checking bench for the touch measurement controller
`timescale 1ns/10ps
`include "rtm_defs.svh"
module rtm_ctrl_bench
  import rtm_pkg::*;
  ;
  logic        mclk = 1'b0, reset = 1'b1, five_wire = 1'b0, touch = 1'b0;
  logic        set_det = 1'b0, set_man = 1'b0, set_trg = 1'b0;
  logic        meas_req = 1'b0, adc_done = 1'b0, status_read = 1'b0;
  logic [2:0]  xsel = 3'h0, ysel = 3'h0, xr, yr;
  rtm_chan_e   meas_chan = RTM_CH_IDLE;
  logic [11:0] adc_code = 12'h000, exp_code = 12'h000, forced = 12'h000;
  logic [11:0] result;
  logic        use_forced = 1'b0, adc_start, rvalid, flag, drdy, pen_low;
  logic        mode_det, mode_trg, irq_out, irq_oe;
  logic [15:0] sw, rnd = 16'hC9E8;
  logic [1:0]  psel;
  int          miscompares = 0, check_count = 0, nconv = 0, nbase = 0;
  always #2 mclk = ~mclk;
  rtm_ctrl u_dut (.mclk(mclk), .reset(reset), .five_wire(five_wire),
    .set_touch_detect_only_mode(set_det), .set_manual_mode(set_man),
    .set_pen_trigger_mode(set_trg),
    .touch_detect_pullup_select(`RTM_PULL_200K),
    .settle_delay(16'h0002),
    .x_multitouch_resistor_select(xsel), .y_multitouch_resistor_select(ysel),
    .meas_req(meas_req), .meas_chan(meas_chan), .pen_sense_low(pen_low),
    .adc_done(adc_done), .adc_code(adc_code), .status_read(status_read),
    .switch_ctrl(sw), .pullup_sel(psel), .x_rsel(xr), .y_rsel(yr),
    .adc_start(adc_start), .result(result), .result_valid(rvalid),
    .touch_detect_flag(flag), .data_ready_flag(drdy),
    .touch_detect_only_mode(mode_det), .pen_trigger_mode(mode_trg),
    .interrupt_request_n_out(irq_out), .interrupt_request_n_oe(irq_oe));
  rtm_panel_model u_panel (.mclk(mclk), .switch_ctrl(sw),
    .five_wire(five_wire), .touch(touch), .pen_sense_low(pen_low));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [15:0] exp_mask(input rtm_chan_e c, input logic f);
    case ({f, c})
      4'h0: return 16'h0023;
      4'h1: return 16'h004C;
      4'h2: return 16'h0031;
      4'h3: return 16'h0091;
      4'h4: return 16'h0110;
      4'h8: return 16'h2603;
      4'h9: return 16'h380C;
      4'hC: return 16'hC000;
      default: return 16'h0000;
    endcase
  endfunction : exp_mask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // converter stand-in answers each start one cycle later
  always @(posedge mclk) begin
    adc_done <= adc_start;
    if (adc_start) begin
      adc_code <= use_forced ? forced : rnd[11:0];
      exp_code <= use_forced ? forced : rnd[11:0];
      nconv <= nconv + 1;
    end
  end
  task pulse(input int k);
    @(posedge mclk);
    case (k)
      0: set_man <= 1'b1;
      1: set_det <= 1'b1;
      2: set_trg <= 1'b1;
      default: status_read <= 1'b1;
    endcase
    @(posedge mclk);
    {set_man, set_det, set_trg, status_read} <= 4'h0;
    @(negedge mclk);
  endtask : pulse
  task measure(input rtm_chan_e c, input logic f);
    @(posedge mclk);
    five_wire <= f;
    meas_req <= 1'b1;
    meas_chan <= c;
    @(posedge mclk);
    meas_req <= 1'b0;
    for (int i = 0; i < 40 && sw === 16'h0000; i++) @(negedge mclk);
    chk(sw, exp_mask(c, f));
    for (int i = 0; i < 60 && rvalid !== 1'b1; i++) @(negedge mclk);
    chk({3'h0, rvalid, result}, {3'h0, 1'b1, exp_code});
    rnd = lfsr(rnd);
    // let the break gap pass so the next request finds the idle state
    repeat (8) @(negedge mclk);
  endtask : measure
  task pen_test(input logic f);
    @(posedge mclk);
    five_wire <= f;
    pulse(1);
    for (int i = 0; i < 40 && sw === 16'h0000; i++) @(negedge mclk);
    chk(sw, exp_mask(RTM_CH_PEN, f));
    for (int n = 0; n < 2; n++) begin
      @(posedge mclk);
      touch <= 1'b1;
      repeat (4) @(negedge mclk);
      chk({14'h0, flag, irq_oe}, 16'h0002);
      @(posedge mclk);
      touch <= 1'b0;
      pulse(3);
      chk({14'h0, flag, irq_oe}, 16'h0001);
    end
    pulse(0);
    chk({15'h0, mode_det}, 16'h0000);
    $display("pen detect test done, five wire %0d", f);
  endtask : pen_test
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    use_forced = 1'b1;
    forced = 12'hFFF;
    measure(RTM_CH_X, 1'b0);
    forced = 12'h000;
    measure(RTM_CH_Y, 1'b0);
    use_forced = 1'b0;
    measure(RTM_CH_Z1, 1'b0);
    measure(RTM_CH_Z2, 1'b0);
    measure(RTM_CH_X, 1'b1);
    measure(RTM_CH_Y, 1'b1);
    chk({14'h0, psel}, {14'h0, `RTM_PULL_200K});
    $display("fixed measurement test done");
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      xsel <= rnd[2:0];
      ysel <= rnd[5:3];
      measure(rtm_chan_e'({1'b0, rnd[8] ? 1'b0 : rnd[10], rnd[9]}), rnd[8]);
      chk({10'h0, xr, yr}, {10'h0, xsel, ysel});
    end
    $display("random measurement test done");
    pen_test(1'b0);
    pen_test(1'b1);
    @(posedge mclk);
    five_wire <= 1'b0;
    nbase = nconv;
    pulse(2);
    chk({15'h0, mode_trg}, 16'h0001);
    @(posedge mclk);
    touch <= 1'b1;
    for (int i = 0; i < 200 && drdy !== 1'b1; i++) @(negedge mclk);
    chk({14'h0, drdy, irq_oe}, 16'h0002);
    chk(16'(nconv - nbase), 16'h0002);
    @(posedge mclk);
    touch <= 1'b0;
    pulse(3);
    pulse(0);
    $display("pen trigger test done");
    end_sim();
  end
endmodule : rtm_ctrl_bench
